/* File: design/pcad_pkg.sv */
package pcad_pkg;
    // host i/o ports of the indirect access pair
    localparam logic [15:0] PCAD_SEL_PORT   = 16'h0CF8;
    localparam logic [15:0] PCAD_WIN_PORT   = 16'h0CFC;
    // fields of config_target_select
    localparam int          PCAD_EN_BIT     = 31;
    localparam int          PCAD_BUS_MSB    = 23;
    localparam int          PCAD_BUS_LSB    = 16;
    localparam int          PCAD_DEV_MSB    = 15;
    localparam int          PCAD_DEV_LSB    = 11;
    localparam int          PCAD_FUNC_MSB   = 10;
    localparam int          PCAD_FUNC_LSB   = 8;
    localparam int          PCAD_REG_MSB    = 7;
    localparam int          PCAD_REG_LSB    = 2;
    localparam logic [31:0] PCAD_SEL_MASK   = 32'h80FF_FFFC;
    localparam logic [31:0] PCAD_SEL_RESET  = 32'h0000_0000;
    // chip select lines ad[31:11]
    localparam int          PCAD_IDSEL_LSB  = 11;
    localparam int          PCAD_IDSEL_W    = 21;
    localparam logic [1:0]  PCAD_TYPE0_CODE = 2'b00;
    localparam logic [1:0]  PCAD_TYPE1_CODE = 2'b01;
    // bridge's own bus number bookkeeping
    localparam logic [7:0]  PCAD_BUS_RESET  = 8'h00;
    localparam logic [7:0]  PCAD_SUB_RESET  = 8'h00;
    localparam logic [4:0]  PCAD_SELF_DEV   = 5'h00;
    localparam logic [5:0]  PCAD_SELF_IDX   = 6'h06;
    localparam logic [31:0] PCAD_NO_DEV     = 32'hFFFF_FFFF;
    // controller apb map
    localparam logic [7:0]  PCAD_HC_ADDR    = 8'h00;
    localparam logic [7:0]  PCAD_HC_WDATA   = 8'h04;
    localparam logic [7:0]  PCAD_HC_CTRL    = 8'h08;
    localparam logic [7:0]  PCAD_HC_STATUS  = 8'h0C;
    localparam logic [7:0]  PCAD_HC_RDATA   = 8'h10;
    localparam int          PCAD_HC_WR_BIT  = 31;
    localparam int          PCAD_HC_GO_BIT  = 8;
    localparam int          PCAD_ST_BUSY    = 0;
    localparam int          PCAD_ST_DONE    = 1;
    localparam int          PCAD_ST_REFUSE  = 2;

    typedef enum logic [1:0] {
        PCAD_D_IDLE = 2'b00,
        PCAD_D_CFG  = 2'b01,
        PCAD_D_FWD  = 2'b10
    } pcad_dev_state_t;

    typedef enum logic [1:0] {
        PCAD_H_IDLE = 2'b00,
        PCAD_H_REQ  = 2'b01,
        PCAD_H_WAIT = 2'b11
    } pcad_host_state_t;
endpackage

/* File: design/pcad_io_if.sv */
`timescale 1ns/100ps
interface pcad_io_if (
    input wire logic clk
);
    logic        io_req;
    logic        io_write;
    logic [15:0] io_addr;
    logic [3:0]  io_be;
    logic [31:0] io_wdata;
    logic        io_ack;
    logic [31:0] io_rdata;

    modport bridge (
        input  io_req,
        input  io_write,
        input  io_addr,
        input  io_be,
        input  io_wdata,
        output io_ack,
        output io_rdata
    );

    modport cpu (
        output io_req,
        output io_write,
        output io_addr,
        output io_be,
        output io_wdata,
        input  io_ack,
        input  io_rdata
    );
endinterface

/* File: design/pcad_bridge.sv */
// Summary of operation
// - only full dword select access is configuration
// - data window access runs the selected transfer
// - byte enables choose the lanes taking part
// - bus number from select bits 23:16
// - device number from select bits 15:11
// - function number from select bits 10:8
// - register index from select bits 7:2
// - one chip select line among ad 31:11
// - bridge keeps bus and subordinate numbers
// - firmware numbers buses ascending down branches
// - only the boot processor issues configuration
`timescale 1ns/100ps
module pcad_bridge (
    input  wire logic        CLK_IN,
    input  wire logic        RST_B_IN,
    pcad_io_if.bridge        IO,
    output logic             CFG_REQ_OUT,
    output logic             CFG_TYPE1_OUT,
    output logic             CFG_WRITE_OUT,
    output logic [31:0]      CFG_ADDR_OUT,
    output logic [3:0]       CFG_BE_OUT,
    output logic [31:0]      CFG_WDATA_OUT,
    input  wire logic        CFG_DONE_IN,
    input  wire logic [31:0] CFG_RDATA_IN,
    output logic             FWD_REQ_OUT,
    output logic             FWD_WRITE_OUT,
    output logic [15:0]      FWD_ADDR_OUT,
    output logic [3:0]       FWD_BE_OUT,
    output logic [31:0]      FWD_WDATA_OUT,
    input  wire logic        FWD_DONE_IN,
    input  wire logic [31:0] FWD_RDATA_IN,
    output logic [7:0]       BUS_NUM_OUT,
    output logic [7:0]       SUB_NUM_OUT
);
    import pcad_pkg::*;

    pcad_dev_state_t state_reg;
    logic [31:0]     sel_reg;
    logic [7:0]      bus_num_reg;
    logic [7:0]      sub_num_reg;
    logic            ack_reg;
    logic [31:0]     rdata_reg;
    logic [31:0]     lane_mask_reg;
    logic            cfg_req_reg;
    logic            cfg_type1_reg;
    logic            cfg_write_reg;
    logic [31:0]     cfg_addr_reg;
    logic [3:0]      cfg_be_reg;
    logic [31:0]     cfg_wdata_reg;
    logic            fwd_req_reg;
    logic            fwd_write_reg;
    logic [15:0]     fwd_addr_reg;
    logic [3:0]      fwd_be_reg;
    logic [31:0]     fwd_wdata_reg;

    wire logic [7:0]  tgt_bus  = sel_reg[PCAD_BUS_MSB:PCAD_BUS_LSB];
    wire logic [4:0]  tgt_dev  = sel_reg[PCAD_DEV_MSB:PCAD_DEV_LSB];
    wire logic [2:0]  tgt_func = sel_reg[PCAD_FUNC_MSB:PCAD_FUNC_LSB];
    wire logic [5:0]  tgt_reg  = sel_reg[PCAD_REG_MSB:PCAD_REG_LSB];

    wire logic take = (state_reg == PCAD_D_IDLE) && IO.io_req;
    // a partial access at the select port falls through to plain i/o
    wire logic hit_sel = (IO.io_addr[15:2] == PCAD_SEL_PORT[15:2])
                         && (IO.io_be == 4'hF);
    wire logic hit_win = (IO.io_addr[15:2] == PCAD_WIN_PORT[15:2])
                         && sel_reg[PCAD_EN_BIT];
    // type 0 on our own bus, type 1 for anything in the range below
    wire logic to_local = (tgt_bus == bus_num_reg);
    wire logic to_below = (tgt_bus > bus_num_reg)
                          && (tgt_bus <= sub_num_reg);
    wire logic to_self  = to_local && (tgt_dev == PCAD_SELF_DEV);
    wire logic dev_ok   = ({27'h000_0000, tgt_dev} < PCAD_IDSEL_W);

    wire logic [PCAD_IDSEL_W-1:0] idsel =
        PCAD_IDSEL_W'(1) << tgt_dev;
    wire logic [31:0] type0_addr = {idsel, tgt_func, tgt_reg,
                                    PCAD_TYPE0_CODE};
    wire logic [31:0] type1_addr = {8'h00, tgt_bus, tgt_dev, tgt_func,
                                    tgt_reg, PCAD_TYPE1_CODE};

    wire logic [31:0] lane_mask = {{8{IO.io_be[3]}}, {8{IO.io_be[2]}},
                                   {8{IO.io_be[1]}}, {8{IO.io_be[0]}}};
    wire logic self_idx = (tgt_reg == PCAD_SELF_IDX);
    wire logic [31:0] self_word = self_idx ?
        {16'h0000, sub_num_reg, bus_num_reg} : 32'h0000_0000;

    wire logic sel_wr  = take && hit_sel && IO.io_write;
    wire logic win_go  = take && !hit_sel && hit_win;
    wire logic self_wr = win_go && to_self && self_idx && IO.io_write;
    wire logic cfg_go  = win_go && !to_self
                         && ((to_local && dev_ok) || to_below);
    wire logic abort   = win_go && !to_self && !cfg_go;
    wire logic fwd_go  = take && !hit_sel && !hit_win;

    // bits 30:24 and 1:0 are not stored, so they read back zero
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            sel_reg <= PCAD_SEL_RESET;
        end else if (sel_wr) begin
            sel_reg <= IO.io_wdata & PCAD_SEL_MASK;
        end
    end

    // firmware loads these through the bridge's own config word
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            bus_num_reg <= PCAD_BUS_RESET;
            sub_num_reg <= PCAD_SUB_RESET;
        end else if (self_wr) begin
            if (IO.io_be[0]) begin
                bus_num_reg <= IO.io_wdata[7:0];
            end
            if (IO.io_be[1]) begin
                sub_num_reg <= IO.io_wdata[15:8];
            end
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            cfg_type1_reg <= 1'b0;
            cfg_write_reg <= 1'b0;
            cfg_addr_reg  <= 32'h0000_0000;
            cfg_be_reg    <= 4'h0;
            cfg_wdata_reg <= 32'h0000_0000;
            fwd_write_reg <= 1'b0;
            fwd_addr_reg  <= 16'h0000;
            fwd_be_reg    <= 4'h0;
            fwd_wdata_reg <= 32'h0000_0000;
            lane_mask_reg <= 32'h0000_0000;
        end else if (take) begin
            cfg_type1_reg <= !to_local;
            cfg_write_reg <= IO.io_write;
            cfg_addr_reg  <= to_local ? type0_addr : type1_addr;
            cfg_be_reg    <= IO.io_be;
            cfg_wdata_reg <= IO.io_wdata & lane_mask;
            fwd_write_reg <= IO.io_write;
            fwd_addr_reg  <= IO.io_addr;
            fwd_be_reg    <= IO.io_be;
            fwd_wdata_reg <= IO.io_wdata;
            lane_mask_reg <= lane_mask;
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            state_reg   <= PCAD_D_IDLE;
            cfg_req_reg <= 1'b0;
            fwd_req_reg <= 1'b0;
            ack_reg     <= 1'b0;
            rdata_reg   <= 32'h0000_0000;
        end else begin
            ack_reg <= 1'b0;
            case (state_reg)
                PCAD_D_IDLE: begin
                    if (take && hit_sel) begin
                        ack_reg   <= 1'b1;
                        rdata_reg <= sel_reg;
                    end else if (win_go && to_self) begin
                        ack_reg   <= 1'b1;
                        rdata_reg <= self_word & lane_mask;
                    end else if (abort) begin
                        // no target: reads float high, writes vanish
                        ack_reg   <= 1'b1;
                        rdata_reg <= PCAD_NO_DEV & lane_mask;
                    end else if (cfg_go) begin
                        cfg_req_reg <= 1'b1;
                        state_reg   <= PCAD_D_CFG;
                    end else if (fwd_go) begin
                        fwd_req_reg <= 1'b1;
                        state_reg   <= PCAD_D_FWD;
                    end
                end
                PCAD_D_CFG: begin
                    if (CFG_DONE_IN) begin
                        cfg_req_reg <= 1'b0;
                        ack_reg     <= 1'b1;
                        rdata_reg   <= CFG_RDATA_IN & lane_mask_reg;
                        state_reg   <= PCAD_D_IDLE;
                    end
                end
                PCAD_D_FWD: begin
                    if (FWD_DONE_IN) begin
                        fwd_req_reg <= 1'b0;
                        ack_reg     <= 1'b1;
                        rdata_reg   <= FWD_RDATA_IN;
                        state_reg   <= PCAD_D_IDLE;
                    end
                end
                default: begin
                    state_reg <= PCAD_D_IDLE;
                end
            endcase
        end
    end

    assign IO.io_ack       = ack_reg;
    assign IO.io_rdata     = rdata_reg;
    assign CFG_REQ_OUT     = cfg_req_reg;
    assign CFG_TYPE1_OUT   = cfg_type1_reg;
    assign CFG_WRITE_OUT   = cfg_write_reg;
    assign CFG_ADDR_OUT    = cfg_addr_reg;
    assign CFG_BE_OUT      = cfg_be_reg;
    assign CFG_WDATA_OUT   = cfg_wdata_reg;
    assign FWD_REQ_OUT     = fwd_req_reg;
    assign FWD_WRITE_OUT   = fwd_write_reg;
    assign FWD_ADDR_OUT    = fwd_addr_reg;
    assign FWD_BE_OUT      = fwd_be_reg;
    assign FWD_WDATA_OUT   = fwd_wdata_reg;
    assign BUS_NUM_OUT     = bus_num_reg;
    assign SUB_NUM_OUT     = sub_num_reg;
endmodule

/* File: design/pcad_cpu.sv */
`timescale 1ns/100ps
module pcad_cpu (
    input  wire logic        CLK_IN,
    input  wire logic        RST_B_IN,
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [7:0]  PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic [31:0]      PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    input  wire logic        BOOT_PROCESSOR_IN,
    pcad_io_if.cpu           IO
);
    import pcad_pkg::*;

    pcad_host_state_t state_reg;
    logic             boot_meta_reg;
    logic             boot_reg;
    logic [15:0]      addr_reg;
    logic             write_reg;
    logic [31:0]      wdata_reg;
    logic [3:0]       be_reg;
    logic [31:0]      rdata_reg;
    logic             done_reg;
    logic             refuse_reg;
    logic             req_reg;
    logic [31:0]      prdata_reg;
    logic             pready_reg;

    wire logic setup  = PSEL_IN && !PENABLE_IN;
    wire logic access = PSEL_IN && PENABLE_IN && pready_reg;
    wire logic wr     = access && PWRITE_IN;
    wire logic wr_addr   = wr && (PADDR_IN == PCAD_HC_ADDR);
    wire logic wr_wdata  = wr && (PADDR_IN == PCAD_HC_WDATA);
    wire logic wr_ctrl   = wr && (PADDR_IN == PCAD_HC_CTRL);
    wire logic wr_status = wr && (PADDR_IN == PCAD_HC_STATUS);
    wire logic busy = (state_reg != PCAD_H_IDLE);
    wire logic go   = wr_ctrl && PWDATA_IN[PCAD_HC_GO_BIT] && !busy;
    // configuration ports are closed to any processor but the boot one
    // partial select access is plain i/o, so it is never gated
    wire logic is_cfg = ((addr_reg[15:2] == PCAD_SEL_PORT[15:2])
                         && (PWDATA_IN[3:0] == 4'hF))
                        || (addr_reg[15:2] == PCAD_WIN_PORT[15:2]);
    wire logic refuse = go && is_cfg && !boot_reg;
    wire logic done_set = (state_reg == PCAD_H_WAIT) && IO.io_ack;

    wire logic [31:0] status_word = {29'h0000_0000, refuse_reg,
                                     done_reg, busy};
    logic [31:0] rd_word;
    always_comb begin
        if (PADDR_IN == PCAD_HC_ADDR) begin
            rd_word = {write_reg, 15'h0000, addr_reg};
        end else if (PADDR_IN == PCAD_HC_WDATA) begin
            rd_word = wdata_reg;
        end else if (PADDR_IN == PCAD_HC_CTRL) begin
            rd_word = {28'h000_0000, be_reg};
        end else if (PADDR_IN == PCAD_HC_STATUS) begin
            rd_word = status_word;
        end else if (PADDR_IN == PCAD_HC_RDATA) begin
            rd_word = rdata_reg;
        end else begin
            rd_word = 32'h0000_0000;
        end
    end

    // strap comes from a pin, so it is synchronised first
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            boot_meta_reg <= 1'b0;
            boot_reg      <= 1'b0;
        end else begin
            boot_meta_reg <= BOOT_PROCESSOR_IN;
            boot_reg      <= boot_meta_reg;
        end
    end

    // zero wait: data is staged in setup, pready rises in access
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
        end else begin
            pready_reg <= setup;
            if (setup) begin
                prdata_reg <= rd_word;
            end
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            addr_reg  <= 16'h0000;
            write_reg <= 1'b0;
            wdata_reg <= 32'h0000_0000;
            be_reg    <= 4'h0;
        end else if (!busy) begin
            if (wr_addr) begin
                addr_reg  <= PWDATA_IN[15:0];
                write_reg <= PWDATA_IN[PCAD_HC_WR_BIT];
            end
            if (wr_wdata) begin
                wdata_reg <= PWDATA_IN;
            end
            if (wr_ctrl) begin
                be_reg <= PWDATA_IN[3:0];
            end
        end
    end

    // a flag set in the same cycle as its clear stays set
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            done_reg   <= 1'b0;
            refuse_reg <= 1'b0;
        end else begin
            done_reg   <= done_set
                          || (done_reg && !(wr_status
                              && PWDATA_IN[PCAD_ST_DONE]));
            refuse_reg <= refuse
                          || (refuse_reg && !(wr_status
                              && PWDATA_IN[PCAD_ST_REFUSE]));
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            state_reg <= PCAD_H_IDLE;
            req_reg   <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            req_reg <= 1'b0;
            case (state_reg)
                PCAD_H_IDLE: begin
                    if (go && !refuse) begin
                        req_reg   <= 1'b1;
                        state_reg <= PCAD_H_REQ;
                    end
                end
                PCAD_H_REQ: begin
                    state_reg <= PCAD_H_WAIT;
                end
                PCAD_H_WAIT: begin
                    if (IO.io_ack) begin
                        rdata_reg <= IO.io_rdata;
                        state_reg <= PCAD_H_IDLE;
                    end
                end
                default: begin
                    state_reg <= PCAD_H_IDLE;
                end
            endcase
        end
    end

    assign IO.io_req    = req_reg;
    assign IO.io_write  = write_reg;
    assign IO.io_addr   = addr_reg;
    assign IO.io_be     = be_reg;
    assign IO.io_wdata  = wdata_reg;
    assign PRDATA_OUT   = prdata_reg;
    assign PREADY_OUT   = pready_reg;
    assign PSLVERR_OUT  = 1'b0;
endmodule

/* File: bench/pcad_checker.sv */
`timescale 1ns/100ps
module pcad_checker (
    input wire logic        CLK_IN,
    input wire logic        RST_B_IN,
    input wire logic        io_req,
    input wire logic        io_write,
    input wire logic [15:0] io_addr,
    input wire logic [3:0]  io_be,
    input wire logic        io_ack,
    input wire logic        CFG_REQ_OUT,
    input wire logic        CFG_TYPE1_OUT,
    input wire logic        CFG_WRITE_OUT,
    input wire logic [31:0] CFG_ADDR_OUT,
    input wire logic [3:0]  CFG_BE_OUT,
    input wire logic [31:0] CFG_WDATA_OUT,
    input wire logic        CFG_DONE_IN,
    input wire logic        FWD_REQ_OUT
);
    import pcad_pkg::*;
    wire        sel_hit = io_addr[15:2] == PCAD_SEL_PORT[15:2];
    wire [31:0] cfg_m   = {{8{CFG_BE_OUT[3]}}, {8{CFG_BE_OUT[2]}},
                           {8{CFG_BE_OUT[1]}}, {8{CFG_BE_OUT[0]}}};
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_B_IN);
    AST_REQ_PULSE: assert property (io_req |=> !io_req)
        else $error("io request longer than one cycle");
    AST_ACK_PULSE: assert property (io_ack |=> !io_ack)
        else $error("io ack longer than one cycle");
    AST_SEL_ACK: assert property (io_req && sel_hit && io_be == 4'hF
        |=> io_ack && !CFG_REQ_OUT && !FWD_REQ_OUT)
        else $error("full select access not answered locally");
    AST_SEL_PART: assert property (io_req && sel_hit && io_be != 4'hF
        |=> FWD_REQ_OUT && !io_ack)
        else $error("partial select access not forwarded");
    AST_IDSEL_ONE: assert property (CFG_REQ_OUT && !CFG_TYPE1_OUT
        |-> $onehot(CFG_ADDR_OUT[31:11]) && CFG_ADDR_OUT[1:0] == 2'b00)
        else $error("type 0 chip select not one line");
    AST_TYPE1_FMT: assert property (CFG_REQ_OUT && CFG_TYPE1_OUT
        |-> CFG_ADDR_OUT[31:24] == 8'h00 && CFG_ADDR_OUT[1:0] == 2'b01)
        else $error("type 1 address format wrong");
    AST_CFG_BE: assert property ($rose(CFG_REQ_OUT)
        |-> CFG_BE_OUT == io_be && CFG_WRITE_OUT == io_write)
        else $error("config lanes or direction differ from host");
    AST_WDATA_LANES: assert property (CFG_REQ_OUT && CFG_WRITE_OUT
        |-> (CFG_WDATA_OUT & ~cfg_m) == 32'h0)
        else $error("disabled lane carries write data");
    AST_CFG_HOLD: assert property (CFG_REQ_OUT && !CFG_DONE_IN
        |=> CFG_REQ_OUT && $stable(CFG_ADDR_OUT))
        else $error("config request dropped before done");
    AST_DONE_ACK: assert property (CFG_REQ_OUT && CFG_DONE_IN
        |=> io_ack && !CFG_REQ_OUT)
        else $error("config done not answered next cycle");
endmodule

/* File: bench/pci_config_access_decode_bench.sv */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
    n_mismatch++; $display("BAD %s exp %h got %h", nm, e, g); end end
module pci_config_access_decode_bench;
    import pcad_pkg::*;
    logic        clk = 1'b0, rst_b = 1'b0, boot = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, c_addr, c_wd, f_wd, rr, q, sv;
    logic        pready, c_req, c_t1, c_wr, f_req, f_wr, s_t1;
    logic [3:0]  c_be, f_be, be;
    logic [15:0] f_addr;
    logic [7:0]  bus_num, sub_num, bsel;
    logic [4:0]  dv;
    logic [1:0]  rq, dn = 2'b00;
    logic [31:0] rdv [2] = '{32'h0000_0000, 32'h0000_0000};
    logic [31:0] s_addr [2], s_wd [2], s_rd [2];
    logic [3:0]  s_be [2];
    logic        s_wr [2];
    int          hits [2] = '{0, 0};
    int          wcnt [2] = '{0, 0};
    int          cmp_count = 0, n_mismatch = 0, cyc = 0;
    logic [31:0] seed = 32'h0000_001C;
    logic [31:0] sel_m = 32'h0000_0000;
    logic [7:0]  bus_m = 8'h00, sub_m = 8'h00;
    logic        boot_m = 1'b1;

    always #25 clk = ~clk;

    pcad_io_if u_pcad_io_if (.clk(clk));
    pcad_cpu u_pcad_cpu (.CLK_IN(clk), .RST_B_IN(rst_b), .PSEL_IN(psel),
        .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(), .BOOT_PROCESSOR_IN(boot), .IO(u_pcad_io_if));
    pcad_bridge u_pcad_bridge (.CLK_IN(clk), .RST_B_IN(rst_b),
        .IO(u_pcad_io_if), .CFG_REQ_OUT(c_req), .CFG_TYPE1_OUT(c_t1),
        .CFG_WRITE_OUT(c_wr), .CFG_ADDR_OUT(c_addr), .CFG_BE_OUT(c_be),
        .CFG_WDATA_OUT(c_wd), .CFG_DONE_IN(dn[0]), .CFG_RDATA_IN(rdv[0]),
        .FWD_REQ_OUT(f_req), .FWD_WRITE_OUT(f_wr), .FWD_ADDR_OUT(f_addr),
        .FWD_BE_OUT(f_be), .FWD_WDATA_OUT(f_wd), .FWD_DONE_IN(dn[1]),
        .FWD_RDATA_IN(rdv[1]), .BUS_NUM_OUT(bus_num),
        .SUB_NUM_OUT(sub_num));
    pcad_checker u_pcad_checker (.CLK_IN(clk), .RST_B_IN(rst_b),
        .io_req(u_pcad_io_if.io_req), .io_write(u_pcad_io_if.io_write),
        .io_addr(u_pcad_io_if.io_addr), .io_be(u_pcad_io_if.io_be),
        .io_ack(u_pcad_io_if.io_ack), .CFG_REQ_OUT(c_req),
        .CFG_TYPE1_OUT(c_t1), .CFG_WRITE_OUT(c_wr), .CFG_ADDR_OUT(c_addr),
        .CFG_BE_OUT(c_be), .CFG_WDATA_OUT(c_wd), .CFG_DONE_IN(dn[0]),
        .FWD_REQ_OUT(f_req));

    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    // far targets answer after 0..2 cycles; idle data toggles
    assign rq = {f_req, c_req};
    always @(posedge clk) begin
        for (int i = 0; i < 2; i++) begin
            if (rq[i] === 1'b1 && dn[i] === 1'b0 && wcnt[i] > 0) begin
                wcnt[i] <= wcnt[i] - 1;
            end else if (rq[i] === 1'b1 && dn[i] === 1'b0) begin
                rr = rnd();
                dn[i] <= 1'b1;
                rdv[i] <= rr;
                s_rd[i] <= rr;
                wcnt[i] <= rnd() % 3;
                hits[i] <= hits[i] + 1;
                s_addr[i] <= i ? {16'h0000, f_addr} : c_addr;
                s_be[i] <= i ? f_be : c_be;
                s_wd[i] <= i ? f_wd : c_wd;
                s_wr[i] <= i ? f_wr : c_wr;
                s_t1 <= c_t1;
            end else begin
                dn[i] <= 1'b0;
                rdv[i] <= ~rdv[i];
            end
        end
    end

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic acc(input logic wr, input logic [15:0] a,
                       input logic [3:0] b4, input logic [31:0] wd);
        logic [31:0] r, m, e, st, ea;
        logic        t1;
        int          h0, h1, n, kind;
        m = {{8{b4[3]}}, {8{b4[2]}}, {8{b4[1]}}, {8{b4[0]}}};
        h0 = hits[0];
        h1 = hits[1];
        apb(1'b1, PCAD_HC_ADDR, {wr, 15'h0000, a}, r);
        apb(1'b1, PCAD_HC_WDATA, wd, r);
        apb(1'b1, PCAD_HC_CTRL, {23'h00_0000, 1'b1, 4'h0, b4}, r);
        n = 0;
        st = 32'h0000_0000;
        while (st[2:1] == 2'b00 && n < 40) begin
            apb(1'b0, PCAD_HC_STATUS, 32'h0000_0000, st);
            n++;
        end
        `CHK("poll", 1'b1, st[2:1] != 2'b00)
        apb(1'b0, PCAD_HC_RDATA, 32'h0000_0000, r);
        apb(1'b1, PCAD_HC_STATUS, 32'h0000_0006, e);
        e = 32'h0000_0000;
        t1 = 1'b0;
        if (!boot_m && ((a == PCAD_SEL_PORT && b4 == 4'hF)
                || a == PCAD_WIN_PORT)) begin
            kind = 4;
        end else if (a == PCAD_SEL_PORT && b4 == 4'hF) begin
            kind = 0;
            if (wr) sel_m = wd & PCAD_SEL_MASK;
            e = sel_m;
        end else if (a != PCAD_WIN_PORT || !sel_m[31]) begin
            kind = 2;
        end else if (sel_m[23:16] == bus_m && sel_m[15:11] == 5'd0) begin
            kind = 0;
            if (sel_m[7:2] == PCAD_SELF_IDX) begin
                if (wr && b4[0]) bus_m = wd[7:0];
                if (wr && b4[1]) sub_m = wd[15:8];
                e = {16'h0000, sub_m, bus_m} & m;
            end
        end else if (sel_m[23:16] == bus_m && sel_m[15:11] <= 5'd20) begin
            kind = 1;
            ea = (32'h1 << (11 + sel_m[15:11])) | {21'h0, sel_m[10:2], 2'b00};
        end else if (sel_m[23:16] > bus_m && sel_m[23:16] <= sub_m) begin
            kind = 1;
            t1 = 1'b1;
            ea = {8'h00, sel_m[23:2], 2'b01};
        end else begin
            kind = 3;
            e = PCAD_NO_DEV & m;
        end
        `CHK("cfg count", h0 + (kind == 1), hits[0])
        `CHK("fwd count", h1 + (kind == 2), hits[1])
        if (kind == 1) begin
            `CHK("cfg addr", ea, s_addr[0])
            `CHK("cfg type", t1, s_t1)
            `CHK("cfg be", b4, s_be[0])
            `CHK("cfg dir", wr, s_wr[0])
            if (wr) `CHK("cfg wdata", wd & m, s_wd[0])
            e = s_rd[0] & m;
        end
        if (kind == 2) begin
            `CHK("fwd addr", {16'h0000, a}, s_addr[1])
            `CHK("fwd be", b4, s_be[1])
            `CHK("fwd dir", wr, s_wr[1])
            if (wr) `CHK("fwd wdata", wd, s_wd[1])
            e = s_rd[1];
        end
        if (kind == 4) `CHK("refuse", 1'b1, st[2])
        else if (!wr) `CHK("io rdata", e, r)
    endtask

    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        acc(1'b1, PCAD_SEL_PORT, 4'hF, rnd());
        acc(1'b0, PCAD_SEL_PORT, 4'hF, 32'h0000_0000);
        acc(1'b1, PCAD_SEL_PORT, 4'h3, rnd());
        acc(1'b0, PCAD_SEL_PORT, 4'hF, 32'h0000_0000);
        $display("test select port done");
        acc(1'b1, PCAD_SEL_PORT, 4'hF, 32'h8000_0018);
        acc(1'b1, PCAD_WIN_PORT, 4'h3, 32'h0000_0502);
        `CHK("bus num", bus_m, bus_num)
        `CHK("sub num", sub_m, sub_num)
        acc(1'b1, PCAD_SEL_PORT, 4'hF, 32'h8200_0018);
        acc(1'b0, PCAD_WIN_PORT, 4'hF, 32'h0000_0000);
        $display("test bus numbers done");
        // buses 1..8 around own bus 2 and subordinate 5
        for (int i = 0; i < 16; i++) begin
            rr = rnd();
            bsel = (i < 8) ? 8'd2 : 8'(i - 7);
            dv = (i == 0) ? 5'd20 : (i == 1) ? 5'd21 : 5'(1 + rr[4:0] % 20);
            sv = {i != 7, 7'h00, bsel, dv, rr[10:8], rr[7:2], 2'b00};
            be = (rr[31:28] == 4'h0) ? 4'h1 : rr[31:28];
            acc(1'b1, PCAD_SEL_PORT, 4'hF, sv);
            acc(rr[27], PCAD_WIN_PORT, be, rnd());
        end
        $display("test decode sweep done");
        apb(1'b0, 8'h14, 32'h0000_0000, q);
        `CHK("unmapped", 32'h0000_0000, q)
        $display("test unmapped done");
        boot <= 1'b0;
        boot_m = 1'b0;
        repeat (3) @(posedge clk);
        acc(1'b0, PCAD_WIN_PORT, 4'hF, 32'h0000_0000);
        $display("test boot gate done");
        give_verdict();
    end
endmodule
